// file: sdlc_tx_pkg.sv
/*
 * constants, carriers and state codes shared by the sdlc transmit set-up
 * block. assumes an axi4-lite master with 32-bit data and byte addresses.
 */
package sdlc_tx_pkg;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_INT_EN    = 8'h00;
    localparam logic [7:0] ADDR_FRAMING   = 8'h04;
    localparam logic [7:0] ADDR_TX_CTRL   = 8'h08;
    localparam logic [7:0] ADDR_COMMAND   = 8'h0c;
    localparam logic [7:0] ADDR_TX_DATA   = 8'h10;
    localparam logic [7:0] ADDR_INT_STAT  = 8'h14;
    localparam logic [7:0] ADDR_INT_MASK  = 8'h18;
    localparam logic [7:0] ADDR_LINE_STAT = 8'h1c;
    localparam logic [7:0] ADDR_VECTOR    = 8'h20;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int IE_EXT       = 0;
    localparam int IE_TX        = 1;
    localparam int IE_SAV       = 2;
    localparam int IE_WAIT      = 3;
    localparam int FM_SDLC      = 0;
    localparam int FM_UNITY     = 1;
    localparam int FM_AUTO      = 2;
    localparam int TC_CRC_EN    = 0;
    localparam int TC_SDLC_CRC  = 1;
    localparam int TC_TX_EN     = 3;
    localparam int CMD_RST_CRC  = 0;
    localparam int CMD_RST_EOM  = 1;
    localparam int IS_EXT       = 0;
    localparam int IS_TX        = 1;
    localparam int LS_CTS       = 0;
    localparam int LS_DCD       = 1;
    localparam int LS_BUF_EMPTY = 2;
    localparam int LS_EOM       = 3;

    // ****************************************************************
    // reset values, line constants, vector codes and response codes
    // ****************************************************************
    localparam logic [15:0] CRC_PRESET    = 16'hffff;
    localparam logic [15:0] CRC_POLY      = 16'h8408;
    localparam logic [7:0]  FLAG_CHAR     = 8'h7e;
    localparam logic [7:0]  VEC_RESET     = 8'h00;
    localparam logic        EOM_RESET     = 1'b1;
    localparam logic [2:0]  VEC_CODE_EXT  = 3'h5;
    localparam logic [2:0]  VEC_CODE_TX   = 3'h4;
    localparam logic [2:0]  VEC_CODE_NONE = 3'h3;
    localparam logic [2:0]  STUFF_LIMIT   = 3'h5;
    localparam logic [4:0]  CHAR_BITS     = 5'h08;
    localparam logic [4:0]  CRC_BITS      = 5'h10;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        TX_MARK = 2'b00,
        TX_FLAG = 2'b01,
        TX_DATA = 2'b10,
        TX_CRC  = 2'b11
    } tx_state_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_t;

endpackage

// file: sync_bits.sv
/*
 * two-stage synchroniser for a group of pins.
 * assumes inputs are asynchronous to clk_sys; reset value is idle high.
 */
`timescale 1ns/1ps
module sync_bits #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] d_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    always_comb begin
        s_d    = s_q;
        s_d.s1 = d_in;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign d_out = s_q.s2;
endmodule

// file: sdlc_transmit_setup.sv
/*
 * one sdlc transmit channel: axi4-lite registers, interrupt status,
 * wait/ready pacing, flag idling, crc and zero insertion on the line.
 * assumes link_clk, cts_n and dcd_n are asynchronous pins; 1x clocking.
 */
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module sdlc_transmit_setup
    import sdlc_tx_pkg::*;
#(
    parameter logic SECOND_CHANNEL = 1'b1
) (
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire sdlc_tx_pkg::axi_req_t axi_req,
    output sdlc_tx_pkg::axi_rsp_t      axi_rsp,
    input  wire logic                  link_clk,
    input  wire logic                  cts_n,
    input  wire logic                  dcd_n,
    output logic                       txd,
    output logic                       wait_ready_n,
    output logic                       irq
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic        aw_ok;
        logic [7:0]  aw_addr;
        logic        w_ok;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        aw_rdy;
        logic        w_rdy;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        ar_rdy;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [3:0]  int_en;
        logic [2:0]  framing;
        logic [3:0]  tx_ctrl;
        logic [1:0]  int_stat;
        logic [1:0]  int_mask;
        logic [7:0]  vec_base;
        logic [7:0]  tx_buf;
        logic        buf_full;
        logic        eom;
        logic [15:0] crc;
        tx_state_t   st;
        logic [15:0] sh;
        logic [4:0]  cnt;
        logic [2:0]  ones;
        logic        txd;
        logic        clk_prev;
        logic        cts_prev;
        logic        dcd_prev;
        logic        eom_prev;
        logic        wait_n;
        logic        irq;
    } state_t;

    state_t     s_q;
    state_t     s_d;
    logic [2:0] pins_s;
    logic       cts_act;
    logic       dcd_act;
    logic       tick;
    logic       run;
    logic       wr_go;
    logic       ev_ext;
    logic       ev_tx;
    logic       rd_stat;
    logic       bit_out;
    logic [2:0] vec_code;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic        b);
        logic fb;
        fb = c[0] ^ b;
        crc_step = (c >> 1) ^ (fb ? CRC_POLY : 16'h0000);
    endfunction

    sync_bits #(
        .W (3)
    ) u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .d_in    ({dcd_n, cts_n, link_clk}),
        .d_out   (pins_s)
    );

    assign cts_act = ~pins_s[1];
    assign dcd_act = ~pins_s[2];
    assign tick    = s_q.clk_prev & ~pins_s[0];
    // data only with cts when auto enables are on
    assign run     = s_q.tx_ctrl[TC_TX_EN]
                   & (cts_act | ~s_q.framing[FM_AUTO]);
    assign wr_go   = s_q.aw_ok & s_q.w_ok & ~s_q.bvalid;

    always_comb begin
        s_d      = s_q;
        ev_tx    = 1'b0;
        rd_stat  = 1'b0;
        bit_out  = 1'b0;
        s_d.clk_prev = pins_s[0];

        // ************************************************************
        // transmitter, one bit per falling link clock edge
        // ************************************************************
        if (tick) begin
            if (!run) begin
                s_d.st   = TX_MARK;
                s_d.txd  = 1'b1;
                s_d.ones = 3'h0;
                s_d.cnt  = 5'h00;
            end else if ((s_q.st == TX_DATA || s_q.st == TX_CRC)
                         && s_q.ones == STUFF_LIMIT) begin
                // zero insertion keeps frame content from looking like a flag
                s_d.txd  = 1'b0;
                s_d.ones = 3'h0;
            end else begin
                if (s_q.cnt == 5'h00) begin
                    if (s_q.st == TX_DATA && !s_q.buf_full && !s_q.eom) begin
                        s_d.sh  = ~s_q.crc;
                        s_d.cnt = CRC_BITS;
                        s_d.st  = TX_CRC;
                        s_d.eom = 1'b1;
                    end else if ((s_q.st == TX_FLAG || s_q.st == TX_DATA)
                                 && s_q.buf_full) begin
                        s_d.sh       = {8'h00, s_q.tx_buf};
                        s_d.cnt      = CHAR_BITS;
                        s_d.st       = TX_DATA;
                        s_d.buf_full = 1'b0;
                        ev_tx        = 1'b1;
                    end else begin
                        s_d.sh  = {8'h00, FLAG_CHAR};
                        s_d.cnt = CHAR_BITS;
                        s_d.st  = TX_FLAG;
                    end
                end
                bit_out = s_d.sh[0];
                s_d.txd = bit_out;
                s_d.sh  = s_d.sh >> 1;
                s_d.cnt = s_d.cnt - 5'h01;
                if (s_d.st == TX_DATA && s_q.tx_ctrl[TC_CRC_EN]) begin
                    s_d.crc = crc_step(s_d.crc, bit_out);
                end
                if (s_d.st == TX_FLAG) begin
                    s_d.ones = 3'h0;
                end else if (bit_out) begin
                    s_d.ones = s_q.ones + 3'h1;
                end else begin
                    s_d.ones = 3'h0;
                end
            end
        end

        // ************************************************************
        // axi4-lite write channel
        // ************************************************************
        if (axi_req.awvalid && s_q.aw_rdy) begin
            s_d.aw_ok   = 1'b1;
            s_d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s_q.w_rdy) begin
            s_d.w_ok   = 1'b1;
            s_d.w_data = axi_req.wdata;
            s_d.w_strb = axi_req.wstrb;
        end
        if (s_q.bvalid && axi_req.bready) begin
            s_d.bvalid = 1'b0;
        end
        if (wr_go) begin
            s_d.aw_ok  = 1'b0;
            s_d.w_ok   = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = RESP_OKAY;
            if (s_q.aw_addr == ADDR_INT_EN) begin
                if (s_q.w_strb[0]) s_d.int_en = s_q.w_data[3:0];
            end else if (s_q.aw_addr == ADDR_FRAMING) begin
                if (s_q.w_strb[0]) s_d.framing = s_q.w_data[2:0];
            end else if (s_q.aw_addr == ADDR_TX_CTRL) begin
                if (s_q.w_strb[0]) s_d.tx_ctrl = s_q.w_data[3:0];
            end else if (s_q.aw_addr == ADDR_COMMAND) begin
                if (s_q.w_strb[0] && s_q.w_data[CMD_RST_CRC]) begin
                    s_d.crc = CRC_PRESET;
                end
                // a crc start in this very tick still sets the latch
                if (s_q.w_strb[0] && s_q.w_data[CMD_RST_EOM]
                    && !(tick && s_d.st == TX_CRC && s_q.st != TX_CRC)) begin
                    s_d.eom = 1'b0;
                end
            end else if (s_q.aw_addr == ADDR_TX_DATA) begin
                // loaded after the buffer moved on, so a byte written in the tick it empties is kept; a write to a full buffer overwrites it
                if (s_q.w_strb[0]) begin
                    s_d.tx_buf   = s_q.w_data[7:0];
                    s_d.buf_full = 1'b1;
                end
            end else if (s_q.aw_addr == ADDR_INT_MASK) begin
                if (s_q.w_strb[0]) s_d.int_mask = s_q.w_data[1:0];
            end else if (s_q.aw_addr == ADDR_VECTOR) begin
                if (s_q.w_strb[0]) s_d.vec_base = s_q.w_data[7:0];
            end else if (s_q.aw_addr == ADDR_INT_STAT
                         || s_q.aw_addr == ADDR_LINE_STAT) begin
                s_d.bresp = RESP_OKAY;
            end else begin
                s_d.bresp = RESP_SLVERR;
            end
        end
        s_d.aw_rdy = ~s_d.aw_ok & ~s_d.bvalid;
        s_d.w_rdy  = ~s_d.w_ok & ~s_d.bvalid;

        // ************************************************************
        // axi4-lite read channel
        // ************************************************************
        if (s_q.int_stat[IS_EXT]) begin
            vec_code = VEC_CODE_EXT;
        end else if (s_q.int_stat[IS_TX]) begin
            vec_code = VEC_CODE_TX;
        end else begin
            vec_code = VEC_CODE_NONE;
        end
        if (s_q.rvalid && axi_req.rready) begin
            s_d.rvalid = 1'b0;
        end
        if (axi_req.arvalid && s_q.ar_rdy) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = RESP_OKAY;
            s_d.rdata  = 32'h0000_0000;
            if (axi_req.araddr == ADDR_INT_EN) begin
                s_d.rdata[3:0] = s_q.int_en;
            end else if (axi_req.araddr == ADDR_FRAMING) begin
                s_d.rdata[2:0] = s_q.framing;
            end else if (axi_req.araddr == ADDR_TX_CTRL) begin
                s_d.rdata[3:0] = s_q.tx_ctrl;
            end else if (axi_req.araddr == ADDR_COMMAND
                         || axi_req.araddr == ADDR_TX_DATA) begin
                s_d.rdata = 32'h0000_0000;
            end else if (axi_req.araddr == ADDR_INT_STAT) begin
                s_d.rdata[1:0] = s_q.int_stat;
                rd_stat        = 1'b1;
            end else if (axi_req.araddr == ADDR_INT_MASK) begin
                s_d.rdata[1:0] = s_q.int_mask;
            end else if (axi_req.araddr == ADDR_LINE_STAT) begin
                s_d.rdata[LS_CTS]       = cts_act;
                s_d.rdata[LS_DCD]       = dcd_act;
                s_d.rdata[LS_BUF_EMPTY] = ~s_q.buf_full;
                s_d.rdata[LS_EOM]       = s_q.eom;
            end else if (axi_req.araddr == ADDR_VECTOR) begin
                // only the second channel holds the vector it alters
                if (s_q.int_en[IE_SAV] && SECOND_CHANNEL) begin
                    s_d.rdata[7:0] = {s_q.vec_base[7:4], vec_code,
                                      s_q.vec_base[0]};
                end else begin
                    s_d.rdata[7:0] = s_q.vec_base;
                end
            end else begin
                s_d.rresp = RESP_SLVERR;
            end
        end
        s_d.ar_rdy = ~s_d.rvalid;

        // ************************************************************
        // interrupts and pacing
        // ************************************************************
        s_d.cts_prev = cts_act;
        s_d.dcd_prev = dcd_act;
        s_d.eom_prev = s_q.eom;
        ev_ext = (cts_act ^ s_q.cts_prev) | (dcd_act ^ s_q.dcd_prev)
               | (s_q.eom ^ s_q.eom_prev);
        // an event in the clearing read still lands
        s_d.int_stat = (rd_stat ? 2'b00 : s_q.int_stat);
        if (ev_ext && s_q.int_en[IE_EXT]) s_d.int_stat[IS_EXT] = 1'b1;
        if (ev_tx && s_q.int_en[IE_TX]) s_d.int_stat[IS_TX] = 1'b1;
        s_d.irq = |(s_d.int_stat & s_d.int_mask);
        s_d.wait_n = ~(s_d.int_en[IE_WAIT] & run & ~s_d.buf_full);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_q          <= '0;
            s_q.eom      <= EOM_RESET;
            s_q.eom_prev <= EOM_RESET;
            s_q.crc      <= CRC_PRESET;
            s_q.vec_base <= VEC_RESET;
            s_q.st       <= TX_MARK;
            s_q.txd      <= 1'b1;
            s_q.clk_prev <= 1'b1;
            s_q.wait_n   <= 1'b1;
            s_q.aw_rdy   <= 1'b1;
            s_q.w_rdy    <= 1'b1;
            s_q.ar_rdy   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign axi_rsp.awready = s_q.aw_rdy;
    assign axi_rsp.wready  = s_q.w_rdy;
    assign axi_rsp.bvalid  = s_q.bvalid;
    assign axi_rsp.bresp   = s_q.bresp;
    assign axi_rsp.arready = s_q.ar_rdy;
    assign axi_rsp.rvalid  = s_q.rvalid;
    assign axi_rsp.rdata   = s_q.rdata;
    assign axi_rsp.rresp   = s_q.rresp;
    assign txd             = s_q.txd;
    assign wait_ready_n    = s_q.wait_n;
    assign irq             = s_q.irq;
endmodule

// file: sdlc_transmit_setup_props.sv
/*
 * checker for the sdlc transmit set-up block, bound to its ports.
 * assumes one clock domain and the link clock sampled by clk_sys.
 */
`timescale 1ns/1ps
module sdlc_transmit_setup_props
    import sdlc_tx_pkg::*;
(
    input wire logic                  clk_sys,
    input wire logic                  resetn,
    input wire sdlc_tx_pkg::axi_req_t axi_req,
    input wire sdlc_tx_pkg::axi_rsp_t axi_rsp,
    input wire logic                  link_clk,
    input wire logic                  cts_n,
    input wire logic                  dcd_n,
    input wire logic                  txd,
    input wire logic                  wait_ready_n,
    input wire logic                  irq
);
    // ****************************************************************
    // cycles since a link fall and since a host or pin event
    // ****************************************************************
    logic       link_q;
    logic       cts_q;
    logic       dcd_q;
    logic [3:0] lk_q;
    logic [3:0] hw_q;
    logic       ev_hw;
    assign ev_hw = (cts_n != cts_q) || (dcd_n != dcd_q) ||
                   (axi_req.wvalid && axi_rsp.wready);
    // counters saturate so a long quiet spell never wraps back to 0
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            link_q <= 1'b1;
            cts_q  <= 1'b1;
            dcd_q  <= 1'b1;
            lk_q   <= 4'hf;
            hw_q   <= 4'hf;
        end else begin
            link_q <= link_clk;
            cts_q  <= cts_n;
            dcd_q  <= dcd_n;
            lk_q   <= (link_q && !link_clk) ? 4'h0 :
                      (lk_q == 4'hf) ? lk_q : lk_q + 4'h1;
            hw_q   <= ev_hw ? 4'h0 : (hw_q == 4'hf) ? hw_q : hw_q + 4'h1;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_wr_taken;
        axi_req.awvalid && axi_rsp.awready &&
        axi_req.wvalid && axi_rsp.wready;
    endsequence

    chk_bresp_delay: assert property (s_wr_taken |-> ##2 axi_rsp.bvalid)
        else $error("write answer late");
    chk_read_delay: assert property (
        axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read answer late");
    chk_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write answer dropped");
    chk_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read answer dropped");
    chk_write_refused: assert property (
        axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
        else $error("write taken while answer pending");
    chk_line_paced: assert property (
        $fell(txd) |-> lk_q inside {[4'h1:4'h7]})
        else $error("line bit not paced by link clock");
    chk_irq_cause: assert property (
        $rose(irq) |-> (hw_q <= 4'ha) || (lk_q <= 4'ha))
        else $error("interrupt without cause");
    chk_ready_cause: assert property (
        $changed(wait_ready_n) |-> (hw_q <= 4'ha) || (lk_q <= 4'ha))
        else $error("wait ready moved without cause");
endmodule

bind sdlc_transmit_setup sdlc_transmit_setup_props u_props (
    .clk_sys(clk_sys), .resetn(resetn), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .link_clk(link_clk), .cts_n(cts_n),
    .dcd_n(dcd_n), .txd(txd), .wait_ready_n(wait_ready_n), .irq(irq));

// file: sdlc_line_rx.sv
/*
 * remote line receiver: makes the 1x link clock and decodes txd.
 * assumes txd settles well before the link clock's rising edge.
 */
`timescale 1ns/1ps
module sdlc_line_rx
    import sdlc_tx_pkg::*;
(
    input  wire logic   run,
    input  wire logic   txd,
    output logic        link_clk,
    output logic [23:0] rx_last3,
    output int          rx_count,
    output int          flag_count
);
    int          ones  = 0;
    int          nbits = 0;
    logic [7:0]  sreg  = 8'hff;
    logic [7:0]  dbyte = 8'h00;
    logic [23:0] last3 = 24'h0;
    int          nbyte = 0;
    int          nflag = 0;
    assign rx_last3   = last3;
    assign rx_count   = nbyte;
    assign flag_count = nflag;
    // clock stands high between runs; 7 ns offset keeps it off clk_sys
    initial begin
        link_clk = 1'b1;
        #7;
        forever begin
            if (run) begin
                #160 link_clk = 1'b0;
                #160 link_clk = 1'b1;
            end else begin
                #40;
            end
        end
    end
    always @(posedge link_clk) begin
        sreg = {txd, sreg[7:1]};
        if (sreg == FLAG_CHAR) begin
            nflag++;
            nbits = 0;
            ones = 0;
        end else if (ones == 5 && !txd) begin
            ones = 0;
        end else begin
            ones = txd ? ones + 1 : 0;
            dbyte = {txd, dbyte[7:1]};
            nbits++;
            if (nbits == 8) begin
                last3 = {last3[15:0], dbyte};
                nbyte++;
                nbits = 0;
            end
        end
    end
endmodule

// file: sdlc_transmit_setup_tb.sv
/*
 * self-checking bench: axi4-lite tasks, line receiver, pin stimulus.
 * assumes the design's default second-channel setting.
 */
`timescale 1ns/1ps
module sdlc_transmit_setup_tb;
    import sdlc_tx_pkg::*;
    logic     clk_sys;
    logic     resetn;
    axi_req_t req;
    axi_rsp_t rsp;
    logic     link_clk;
    logic     cts_n;
    logic     dcd_n;
    logic     txd;
    logic     wait_ready_n;
    logic     irq;
    logic     run;
    logic [23:0] rx_last3;
    int       rx_count;
    int       flag_count;
    int       fail_count;
    int       num_checks;

    sdlc_transmit_setup DUT (.clk_sys(clk_sys), .resetn(resetn),
        .axi_req(req), .axi_rsp(rsp), .link_clk(link_clk), .cts_n(cts_n),
        .dcd_n(dcd_n), .txd(txd), .wait_ready_n(wait_ready_n), .irq(irq));
    sdlc_line_rx u_rx (.run(run), .txd(txd), .link_clk(link_clk),
        .rx_last3(rx_last3), .rx_count(rx_count), .flag_count(flag_count));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ****************************************************************
    // bus tasks and checks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dat,
                      output logic [1:0] r);
        bit aw;
        bit w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk_sys);
        req.awaddr <= a;
        req.wdata <= dat;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_sys);
            if (rsp.awready && req.awvalid) begin
                aw = 1'b1;
                req.awvalid <= 1'b0;
            end
            if (rsp.wready && req.wvalid) begin
                w = 1'b1;
                req.wvalid <= 1'b0;
            end
        end
        while (rsp.bvalid !== 1'b1) @(posedge clk_sys);
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dat,
                      output logic [1:0] r);
        @(posedge clk_sys);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do @(posedge clk_sys); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        while (rsp.rvalid !== 1'b1) @(posedge clk_sys);
        dat = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask
    task automatic wo(input logic [7:0] a, input logic [31:0] dat);
        logic [1:0] r;
        wr(a, dat, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, exp);
    endtask
    function automatic logic [15:0] crc8(input logic [15:0] c,
                                         input logic [7:0] d);
        for (int i = 0; i < 8; i++)
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        return c;
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #2000000;
        fail_count++;
        final_report();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        int n;
        int k;
        logic [31:0] d;
        logic [1:0]  r;
        logic [15:0] c;
        fail_count = 0;
        num_checks = 0;
        req = '0;
        run = 1'b0;
        cts_n = 1'b1;
        dcd_n = 1'b1;
        resetn = 1'b0;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        rdc(ADDR_LINE_STAT, 32'hc);
        rd(8'h24, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h24, 32'h1, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        rdc(ADDR_TX_DATA, 32'h0);
        $display("test registers done");
        wo(ADDR_INT_EN, 32'hb);
        wo(ADDR_INT_MASK, 32'h3);
        wo(ADDR_FRAMING, 32'h7);
        wo(ADDR_TX_CTRL, 32'h2);
        wo(ADDR_COMMAND, 32'h1);
        wo(ADDR_TX_CTRL, 32'hb);
        run <= 1'b1;
        // auto enables hold the line at mark until cts goes active
        repeat (200) @(posedge clk_sys);
        chk(txd, 1'b1);
        chk(flag_count, 0);
        chk(irq, 1'b0);
        cts_n <= 1'b0;
        for (n = 0; n < 50 && irq !== 1'b1; n++) @(posedge clk_sys);
        chk(irq, 1'b1);
        rdc(ADDR_INT_STAT, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk(irq, 1'b0);
        for (n = 0; n < 2000 && flag_count < 3; n++) @(posedge clk_sys);
        chk(flag_count >= 3, 1'b1);
        chk(wait_ready_n, 1'b0);
        rdc(ADDR_LINE_STAT, 32'hd);
        $display("test flag idle done");
        wo(ADDR_COMMAND, 32'h2);
        c = crc8(16'hffff, FLAG_CHAR);
        k = rx_count;
        wo(ADDR_TX_DATA, {24'h0, FLAG_CHAR});
        for (n = 0; n < 4000 && rx_count < k + 3; n++) @(posedge clk_sys);
        chk(rx_last3, {FLAG_CHAR, ~c[7:0], ~c[15:8]});
        rdc(ADDR_INT_STAT, 32'h3);
        chk(wait_ready_n, 1'b0);
        $display("test frame done");
        wo(ADDR_INT_EN, 32'hf);
        wo(ADDR_VECTOR, 32'ha1);
        rdc(ADDR_VECTOR, 32'ha7);
        dcd_n <= 1'b0;
        for (n = 0; n < 50 && irq !== 1'b1; n++) @(posedge clk_sys);
        rdc(ADDR_VECTOR, 32'hab);
        rdc(ADDR_INT_STAT, 32'h1);
        wo(ADDR_INT_MASK, 32'h0);
        dcd_n <= 1'b1;
        repeat (20) @(posedge clk_sys);
        chk(irq, 1'b0);
        rdc(ADDR_INT_STAT, 32'h1);
        $display("test vector done");
        cts_n <= 1'b1;
        repeat (20) @(posedge clk_sys);
        k = 0;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_sys);
            if (txd !== 1'b1 || wait_ready_n !== 1'b1) k++;
        end
        chk(k, 0);
        // auto enables off: tx enable alone starts the flags again
        wo(ADDR_FRAMING, 32'h3);
        k = flag_count;
        for (n = 0; n < 500 && flag_count < k + 2; n++) @(posedge clk_sys);
        chk(flag_count >= k + 2, 1'b1);
        chk(wait_ready_n, 1'b0);
        $display("test stop done");
        final_report();
    end
endmodule
